// >>> pcg_pkg.sv
/*
 * Shared constants and types of the peripheral clock gating block: register
 * offsets, field positions, writable masks, reset values and unit mapping.
 * Assumes a 32-bit classic Wishbone register bus and nine gated units.
 */
package pcg_pkg;

   // ********************************
   // Address map
   // ********************************
   localparam logic [31:0] BASE_ADDR = 32'h400f_e000;
   localparam logic [11:0] OFF_RUN_CLOCK_CFG = 12'h060;
   localparam logic [11:0] OFF_RUN_FIRST = 12'h100;
   localparam logic [11:0] OFF_RUN_SECOND = 12'h104;
   localparam logic [11:0] OFF_SLEEP_FIRST = 12'h110;
   localparam logic [11:0] OFF_SLEEP_SECOND = 12'h114;
   localparam logic [11:0] OFF_DEEP_FIRST = 12'h120;
   localparam logic [11:0] OFF_DEEP_SECOND = 12'h124;
   localparam logic [11:0] OFF_IRQ_STATUS = 12'h200;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h204;
   localparam logic [11:0] OFF_GATE_STATE = 12'h208;

   // ********************************
   // Field positions
   // ********************************
   localparam int BIT_PWM = 20;
   localparam int BIT_ADC0 = 16;
   localparam int BIT_WDT = 3;
   localparam int BIT_TIMER_ONE_GATE = 17;
   localparam int BIT_TIMER_ZERO_GATE = 16;
   localparam int BIT_TWO_WIRE0 = 12;
   localparam int BIT_SYNC_SERIAL0 = 4;
   localparam int BIT_SERIAL1 = 1;
   localparam int BIT_SERIAL0 = 0;
   localparam int BIT_AUTO_CLOCK_GATING = 27;
   localparam int IRQ_FAULT = 0;
   localparam int IRQ_MODE_CHANGE = 1;

   // ********************************
   // Writable masks and reset values
   // ********************************
   localparam logic [31:0] MASK_FIRST = 32'h0011_0008;
   localparam logic [31:0] MASK_SECOND = 32'h0003_1013;
   localparam logic [31:0] MASK_RUN_CLOCK_CFG = 32'h0800_0000;
   localparam logic [31:0] RESET_GATING = 32'h0000_0000;
   localparam logic [31:0] RESET_RUN_CLOCK_CFG = 32'h0000_0000;
   localparam logic [1:0] RESET_IRQ = 2'h0;

   // ********************************
   // Gated units
   // ********************************
   localparam int NUM_UNITS = 9;
   // Unit order: serial0, serial1, sync serial0, two-wire0, timer_zero_gate, timer_one_gate,
   // watchdog, converter0, pulse-width generator.
   localparam logic [8:0] UNIT_IN_SECOND = 9'h03f;
   localparam int UNIT_BIT [NUM_UNITS] = '{BIT_SERIAL0, BIT_SERIAL1,
      BIT_SYNC_SERIAL0, BIT_TWO_WIRE0, BIT_TIMER_ZERO_GATE, BIT_TIMER_ONE_GATE, BIT_WDT,
      BIT_ADC0, BIT_PWM};

   typedef enum logic [1:0] {PM_RUN, PM_SLEEP, PM_DEEP_SLEEP} pcg_mode_t;

endpackage

// >>> pcg_gate_sel.sv
/*
 * Combinational selection of each unit's effective clock enable from the
 * run, sleep or deep-sleep gating registers.
 * Assumes the power mode input is synchronous to the system clock.
 */
`timescale 1ns/1ps
module pcg_gate_sel #(
   parameter int UNITS = pcg_pkg::NUM_UNITS
) (
   input wire logic [31:0] run_first_i,
   input wire logic [31:0] run_second_i,
   input wire logic [31:0] sleep_first_i,
   input wire logic [31:0] sleep_second_i,
   input wire logic [31:0] deep_first_i,
   input wire logic [31:0] deep_second_i,
   input wire logic auto_gating_i,
   input wire pcg_pkg::pcg_mode_t mode_i,
   output logic [UNITS-1:0] gate_en_o
);

   logic [31:0] first_sel;
   logic [31:0] second_sel;

   always_comb begin
      first_sel = run_first_i;
      second_sel = run_second_i;
      if (auto_gating_i) begin
         case (mode_i)
            pcg_pkg::PM_SLEEP: begin
               first_sel = sleep_first_i;
               second_sel = sleep_second_i;
            end
            pcg_pkg::PM_DEEP_SLEEP: begin
               first_sel = deep_first_i;
               second_sel = deep_second_i;
            end
            default: begin
               first_sel = run_first_i;
               second_sel = run_second_i;
            end
         endcase
      end
   end

   for (genvar u = 0; u < UNITS; u++) begin : g_unit
      assign gate_en_o[u] = pcg_pkg::UNIT_IN_SECOND[u] ?
         second_sel[pcg_pkg::UNIT_BIT[u]] : first_sel[pcg_pkg::UNIT_BIT[u]];
   end

endmodule

// >>> pcg_fault_chk.sv
/*
 * Combinational check of a peripheral access against the current gates.
 * Assumes one access request per cycle with a unit index beside it.
 */
`timescale 1ns/1ps
module pcg_fault_chk #(
   parameter int UNITS = pcg_pkg::NUM_UNITS
) (
   input wire logic req_i,
   input wire logic [3:0] unit_i,
   input wire logic [UNITS-1:0] gate_en_i,
   output logic fault_o
);

   always_comb begin
      fault_o = 1'b0;
      // An index outside the gated units is never faulted.
      if (req_i && (int'(unit_i) < UNITS)) begin
         fault_o = !gate_en_i[unit_i];
      end
   end

endmodule

// >>> pcg_top.sv
/*
 * Peripheral clock gating block: gating registers for run, sleep and
 * deep-sleep operation, a run clock configuration register, an interrupt
 * status and mask pair, the registered per-unit clock enables and the bus
 * fault answer for accesses to unclocked units.
 * Assumes a classic Wishbone master on the system clock, synchronous inputs
 * and external clock gating cells driven by gate_en_o.
 */
// How it works
// - Enable bit one clocks its unit.
// - Access to unclocked unit returns bus fault.
// - All gating bits are zero after reset.
// - Run, sleep, deep-sleep sets share one layout.
// - Sleep sets apply only with auto gating.
// - Deep first bit 20 gates pulse-width generator.
// - Deep first bit 16 gates converter zero.
// - Deep first bit 3 gates watchdog.
// - Run second bit 16 gates timer zero.
// - Run second bit 12 gates two-wire zero.
// - Run second bit 4 gates sync serial.
// - Run second bit 1 gates serial one.
// - Run second bit 0 gates serial zero.
// - Registers decode from the system control base.
// - Run second bit 17 gates timer one.
`timescale 1ns/1ps
module pcg_top #(
   parameter int UNITS = pcg_pkg::NUM_UNITS
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone slave.
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [31:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic err_o,
   // Processor power mode.
   input wire pcg_pkg::pcg_mode_t power_mode_i,
   // Peripheral access monitor.
   input wire logic periph_req_i,
   input wire logic [3:0] periph_unit_i,
   output logic periph_fault_o,
   // Clock enables to the gating cells.
   output logic [UNITS-1:0] gate_en_o,
   output logic irq_o
);

   // ********************************
   // State
   // ********************************
   typedef enum logic {BUS_IDLE, BUS_RESP} pcg_bus_st_t;

   typedef struct packed {
      pcg_bus_st_t bus_st;
      logic ack;
      logic err;
      logic [31:0] rdat;
      logic [31:0] run_clock_cfg;
      logic [31:0] run_first;
      logic [31:0] run_second;
      logic [31:0] sleep_first;
      logic [31:0] sleep_second;
      logic [31:0] deep_first;
      logic [31:0] deep_second;
      logic [1:0] irq_status;
      logic [1:0] irq_mask;
      logic irq;
      logic [UNITS-1:0] gate;
      logic fault;
      pcg_pkg::pcg_mode_t mode_prev;
   } pcg_state_t;

   pcg_state_t state_q;
   pcg_state_t state_d;

   logic [UNITS-1:0] gate_next;
   logic fault_now;
   logic bus_req;
   logic in_base;
   logic [11:0] offset;
   logic [31:0] byte_mask;
   logic hit;
   logic [31:0] rd_val;
   logic [1:0] irq_set;
   logic [1:0] irq_clr;

   // ********************************
   // Gate selection and fault check
   // ********************************
   pcg_gate_sel #(
      .UNITS(UNITS)
   ) u_gate_sel (
      .run_first_i(state_q.run_first),
      .run_second_i(state_q.run_second),
      .sleep_first_i(state_q.sleep_first),
      .sleep_second_i(state_q.sleep_second),
      .deep_first_i(state_q.deep_first),
      .deep_second_i(state_q.deep_second),
      .auto_gating_i(state_q.run_clock_cfg[pcg_pkg::BIT_AUTO_CLOCK_GATING]),
      .mode_i(power_mode_i),
      .gate_en_o(gate_next)
   );

   // Faults are judged against the enables currently driven to the units.
   pcg_fault_chk #(
      .UNITS(UNITS)
   ) u_fault_chk (
      .req_i(periph_req_i),
      .unit_i(periph_unit_i),
      .gate_en_i(state_q.gate),
      .fault_o(fault_now)
   );

   // ********************************
   // Bus decode
   // ********************************
   assign bus_req = cyc_i && stb_i && (state_q.bus_st == BUS_IDLE);
   assign in_base = (adr_i[31:12] == pcg_pkg::BASE_ADDR[31:12]);
   assign offset = adr_i[11:0];

   always_comb begin
      for (int b = 0; b < 4; b++) begin
         byte_mask[b*8 +: 8] = {8{sel_i[b]}};
      end
   end

   always_comb begin
      hit = in_base;
      rd_val = 32'h0000_0000;
      case (offset)
         pcg_pkg::OFF_RUN_CLOCK_CFG: begin
            rd_val = state_q.run_clock_cfg;
         end
         pcg_pkg::OFF_RUN_FIRST: begin
            rd_val = state_q.run_first;
         end
         pcg_pkg::OFF_RUN_SECOND: begin
            rd_val = state_q.run_second;
         end
         pcg_pkg::OFF_SLEEP_FIRST: begin
            rd_val = state_q.sleep_first;
         end
         pcg_pkg::OFF_SLEEP_SECOND: begin
            rd_val = state_q.sleep_second;
         end
         pcg_pkg::OFF_DEEP_FIRST: begin
            rd_val = state_q.deep_first;
         end
         pcg_pkg::OFF_DEEP_SECOND: begin
            rd_val = state_q.deep_second;
         end
         pcg_pkg::OFF_IRQ_STATUS: begin
            rd_val = {30'h0000_0000, state_q.irq_status};
         end
         pcg_pkg::OFF_IRQ_MASK: begin
            rd_val = {30'h0000_0000, state_q.irq_mask};
         end
         pcg_pkg::OFF_GATE_STATE: begin
            rd_val = 32'(state_q.gate);
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // Merges write data into a register under the byte lanes and the
   // writable bits; reserved bits stay zero whatever software writes.
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wmask);
      logic [31:0] lanes;
      lanes = byte_mask & wmask;
      merge = (old & ~lanes) | (dat_i & lanes);
   endfunction

   // ********************************
   // Next state
   // ********************************
   always_comb begin
      state_d = state_q;
      irq_set = 2'h0;
      irq_clr = 2'h0;
      state_d.ack = 1'b0;
      state_d.err = 1'b0;

      // Wishbone: answer one cycle after the request, then hold off one
      // cycle so the released strobe is not taken as a second request.
      case (state_q.bus_st)
         BUS_IDLE: begin
            if (bus_req) begin
               state_d.bus_st = BUS_RESP;
               state_d.ack = hit;
               state_d.err = !hit;
               state_d.rdat = (hit && !we_i) ? rd_val : 32'h0000_0000;
               if (hit && we_i) begin
                  case (offset)
                     pcg_pkg::OFF_RUN_CLOCK_CFG: begin
                        state_d.run_clock_cfg = merge(state_q.run_clock_cfg,
                           pcg_pkg::MASK_RUN_CLOCK_CFG);
                     end
                     pcg_pkg::OFF_RUN_FIRST: begin
                        state_d.run_first = merge(state_q.run_first,
                           pcg_pkg::MASK_FIRST);
                     end
                     pcg_pkg::OFF_RUN_SECOND: begin
                        // Timers, two-wire, sync serial and both serial ports.
                        state_d.run_second = merge(state_q.run_second,
                           pcg_pkg::MASK_SECOND);
                     end
                     pcg_pkg::OFF_SLEEP_FIRST: begin
                        state_d.sleep_first = merge(state_q.sleep_first,
                           pcg_pkg::MASK_FIRST);
                     end
                     pcg_pkg::OFF_SLEEP_SECOND: begin
                        state_d.sleep_second = merge(state_q.sleep_second,
                           pcg_pkg::MASK_SECOND);
                     end
                     pcg_pkg::OFF_DEEP_FIRST: begin
                        // Pulse-width generator, converter zero, watchdog.
                        state_d.deep_first = merge(state_q.deep_first,
                           pcg_pkg::MASK_FIRST);
                     end
                     pcg_pkg::OFF_DEEP_SECOND: begin
                        state_d.deep_second = merge(state_q.deep_second,
                           pcg_pkg::MASK_SECOND);
                     end
                     pcg_pkg::OFF_IRQ_STATUS: begin
                        if (sel_i[0]) begin
                           irq_clr = dat_i[1:0];
                        end
                     end
                     pcg_pkg::OFF_IRQ_MASK: begin
                        if (sel_i[0]) begin
                           state_d.irq_mask = dat_i[1:0];
                        end
                     end
                     default: begin
                        state_d.irq_mask = state_q.irq_mask;
                     end
                  endcase
               end
            end
         end
         BUS_RESP: begin
            state_d.bus_st = BUS_IDLE;
         end
         default: begin
            state_d.bus_st = BUS_IDLE;
         end
      endcase

      // Unit enables and the fault answer.
      state_d.gate = gate_next;
      state_d.fault = fault_now;

      // Events: a faulted access and a change of power mode.
      state_d.mode_prev = power_mode_i;
      irq_set[pcg_pkg::IRQ_FAULT] = fault_now;
      irq_set[pcg_pkg::IRQ_MODE_CHANGE] = (power_mode_i != state_q.mode_prev);

      // A set in the same cycle as its clear wins.
      state_d.irq_status = (state_q.irq_status & ~irq_clr) | irq_set;
      state_d.irq = |(state_d.irq_status & state_d.irq_mask);

      if (rst_i) begin
         state_d.bus_st = BUS_IDLE;
         state_d.ack = 1'b0;
         state_d.err = 1'b0;
         state_d.rdat = 32'h0000_0000;
         state_d.run_clock_cfg = pcg_pkg::RESET_RUN_CLOCK_CFG;
         state_d.run_first = pcg_pkg::RESET_GATING;
         state_d.run_second = pcg_pkg::RESET_GATING;
         state_d.sleep_first = pcg_pkg::RESET_GATING;
         state_d.sleep_second = pcg_pkg::RESET_GATING;
         state_d.deep_first = pcg_pkg::RESET_GATING;
         state_d.deep_second = pcg_pkg::RESET_GATING;
         state_d.irq_status = pcg_pkg::RESET_IRQ;
         state_d.irq_mask = pcg_pkg::RESET_IRQ;
         state_d.irq = 1'b0;
         state_d.gate = '0;
         state_d.fault = 1'b0;
         state_d.mode_prev = pcg_pkg::PM_RUN;
      end
   end

   // ********************************
   // Registers
   // ********************************
   // The clock enable freezes everything, reset included.
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         state_q <= state_d;
      end
   end

   // ********************************
   // Outputs
   // ********************************
   assign dat_o = state_q.rdat;
   assign ack_o = state_q.ack;
   assign err_o = state_q.err;
   assign gate_en_o = state_q.gate;
   assign periph_fault_o = state_q.fault;
   assign irq_o = state_q.irq;

endmodule

// >>> pcg_periph_model.sv
/*
 * Model of the gated peripherals: issues one access to a chosen unit.
 * Assumes the bench pulses go_i for one cycle per access.
 */
`timescale 1ns/1ps
module pcg_periph_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic go_i,
   input wire logic [3:0] sel_i,
   output logic req_o,
   output logic [3:0] unit_o
);
   // Between accesses the unit index keeps changing, so no stale value lingers.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_o <= 1'b0;
         unit_o <= 4'h0;
      end else if (go_i) begin
         req_o <= 1'b1;
         unit_o <= sel_i;
      end else begin
         req_o <= 1'b0;
         unit_o <= ~unit_o;
      end
   end
endmodule

// >>> pcg_top_monitor.sv
/*
 * Port checker of the clock gating block.
 * Assumes ce_i stays high and is bound to pcg_top.
 */
`timescale 1ns/1ps
module pcg_top_monitor #(
   parameter int UNITS = 9
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [31:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic err_o,
   input wire pcg_pkg::pcg_mode_t power_mode_i,
   input wire logic periph_req_i,
   input wire logic [3:0] periph_unit_i,
   input wire logic periph_fault_o,
   input wire logic [UNITS-1:0] gate_en_o,
   input wire logic irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i && ce_i))
      else $error("ack without request");
   a_err_base: assert property (cyc_i && stb_i && ce_i && !ack_o && !err_o
      && !$past(ack_o || err_o) && adr_i[31:12] != 20'h400fe |=> err_o && !ack_o)
      else $error("foreign address not refused");
   a_fault_gated: assert property (periph_req_i && ce_i && periph_unit_i < 4'h9
      && !gate_en_o[periph_unit_i] |=> periph_fault_o)
      else $error("access to unclocked unit not faulted");
   a_fault_clocked: assert property (periph_req_i && ce_i && (periph_unit_i > 4'h8
      || gate_en_o[periph_unit_i]) |=> !periph_fault_o)
      else $error("fault on clocked unit");
   a_fault_cause: assert property (periph_fault_o |-> $past(periph_req_i))
      else $error("fault without access");
   a_reset_clear: assert property ($fell(rst_i) |-> gate_en_o == '0 && !irq_o)
      else $error("gates not clear after reset");
   a_gate_hold: assert property (!ack_o && !$past(ack_o) && $stable(power_mode_i)
      && $past(power_mode_i, 2) == $past(power_mode_i) |=> $stable(gate_en_o))
      else $error("gates moved without cause");
endmodule

bind pcg_top pcg_top_monitor #(.UNITS(UNITS)) u_pcg_top_monitor (.clk_i, .rst_i, .ce_i,
   .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .err_o, .power_mode_i,
   .periph_req_i, .periph_unit_i, .periph_fault_o, .gate_en_o, .irq_o);

// >>> peripheral_clock_gating_bench.sv
/*
 * Self-checking bench of the clock gating block over Wishbone.
 * Assumes pcg_top, pcg_periph_model and the bound checker are compiled.
 */
`timescale 1ns/1ps
module peripheral_clock_gating_bench;
   localparam logic [31:0] R1 = 32'h400f_e100;
   localparam logic [31:0] R2 = 32'h400f_e104;
   localparam logic [31:0] D1 = 32'h400f_e120;
   localparam logic [31:0] CF = 32'h400f_e060;
   localparam logic [31:0] ST = 32'h400f_e200;
   localparam logic [31:0] MK = 32'h400f_e204;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic go = 1'b0;
   logic e;
   logic [31:0] adr_i = 32'h0;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] rd;
   logic [3:0] sel_i = 4'hf;
   logic [3:0] unit_sel = 4'h0;
   pcg_pkg::pcg_mode_t power_mode_i = pcg_pkg::PM_RUN;
   logic [31:0] dat_o;
   logic ack_o, err_o, periph_req_i, periph_fault_o, irq_o;
   logic [3:0] periph_unit_i;
   logic [8:0] gate_en_o;
   int err_total = 0;
   int compares = 0;
   int bits [9] = '{0, 1, 4, 12, 16, 17, 3, 16, 20};

   always #4 clk_i = ~clk_i;

   pcg_top u_pcg_top (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i,
      .sel_i, .dat_i, .dat_o, .ack_o, .err_o, .power_mode_i, .periph_req_i,
      .periph_unit_i, .periph_fault_o, .gate_en_o, .irq_o);
   pcg_periph_model u_pcg_periph_model (.clk_i, .rst_i, .go_i(go), .sel_i(unit_sel),
      .req_o(periph_req_i), .unit_o(periph_unit_i));

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      @(posedge clk_i);
      while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 50) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 50) begin
         chk("bus answer", 32'h1, 32'h0);
      end
      rd = dat_o;
      e = err_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic gate(input logic [8:0] x);
      repeat (2) @(posedge clk_i);
      chk("gate_en", {23'h0, x}, {23'h0, gate_en_o});
   endtask

   task automatic acc(input logic [3:0] u, input logic f);
      go <= 1'b1;
      unit_sel <= u;
      @(posedge clk_i);
      go <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk("fault", {31'h0, f}, {31'h0, periph_fault_o});
   endtask

   task automatic wrap_up;
      $display("Comparisons %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ********************************
   // Tests
   // ********************************
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("gate_en", 32'h0, {23'h0, gate_en_o});
      wb(1'b0, R2, 32'h0);
      chk("run2", 32'h0, rd);
      wb(1'b0, D1, 32'h0);
      chk("deep1", 32'h0, rd);
      acc(4'h0, 1'b1);
      wb(1'b1, R2, 32'hffff_ffff);
      wb(1'b0, R2, 32'h0);
      chk("run2", 32'h0003_1013, rd);
      wb(1'b1, D1, 32'hffff_ffff);
      wb(1'b0, D1, 32'h0);
      chk("deep1", 32'h0011_0008, rd);
      gate(9'h03f);
      acc(4'h4, 1'b0);
      acc(4'h6, 1'b1);
      acc(4'hc, 1'b0);
      for (int u = 0; u < 9; u++) begin
         wb(1'b1, R2, u < 6 ? 32'h1 << bits[u] : 32'h0);
         wb(1'b1, R1, u < 6 ? 32'h0 : 32'h1 << bits[u]);
         gate(9'h1 << u);
      end
      wb(1'b1, R1, 32'h0);
      wb(1'b1, R2, 32'hffff_ffff);
      wb(1'b1, CF, 32'h0800_0000);
      power_mode_i <= pcg_pkg::PM_DEEP_SLEEP;
      gate(9'h1c0);
      power_mode_i <= pcg_pkg::PM_SLEEP;
      gate(9'h000);
      wb(1'b1, CF, 32'h0);
      gate(9'h03f);
      acc(4'h7, 1'b1);
      chk("irq masked", 32'h0, {31'h0, irq_o});
      wb(1'b1, MK, 32'h1);
      @(posedge clk_i);
      chk("irq", 32'h1, {31'h0, irq_o});
      wb(1'b0, ST, 32'h0);
      chk("status", 32'h3, rd);
      wb(1'b1, ST, 32'h3);
      wb(1'b0, ST, 32'h0);
      chk("status", 32'h0, rd);
      chk("irq", 32'h0, {31'h0, irq_o});
      wb(1'b0, R2, 32'h0);
      wb(1'b1, R2, rd & ~32'h1);
      gate(9'h03e);
      wb(1'b0, 32'h400f_e300, 32'h0);
      chk("err", 32'h1, {31'h0, e});
      wb(1'b1, 32'h400e_e104, 32'h0);
      chk("err", 32'h1, {31'h0, e});
      wb(1'b0, R2, 32'h0);
      chk("run2", 32'h0003_1012, rd);
      ce_i <= 1'b0;
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk("gate_en frozen", 32'h0000_003e, {23'h0, gate_en_o});
      ce_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("gate_en", 32'h0, {23'h0, gate_en_o});
      wb(1'b0, R2, 32'h0);
      chk("run2", 32'h0, rd);
      wrap_up;
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      $display("MISMATCH watchdog expected done seen hang");
      wrap_up;
   end
endmodule
